// ### logic/i2c_master_stop_arbitration.sv
/*
  I2C master condition sequencer with clock arbitration and bus
  collision handling, reached over APB. Assumes open-drain SCL/SDA
  resolved outside; line inputs are asynchronous to mclk.
*/
// Implementation choices: register access over APB and the placing of the registers.
// How it works
// - buffer write during sequence sets write collision
// - stop sequence first drives SDA low
// - SDA low: count, release SCL, then SDA
// - stop seen loads count; at expiry set flag and clear enable
// - released SCL pauses baud until sampled high
// - sleep keeps working; wake when interrupt enabled
// - reset disables port, aborts transfer
// - start/stop detect bits cleared when disabled
// - stop while not busy raises port flag
// - released one read low is collision
// - collision in transmit clears full, releases lines
// - collision in condition clears its enable
// - after collision, bus stop sets port flag
// - new write restarts at first data bit
// - line low at start is collision
// - start: SDA high loads count; SCL low collides
// - SDA low in first count: assert early
// - second start count ignores SCL, then SCL low
// - repeated start: SDA low at SCL high collides
// - SCL falls before SDA asserted collides
// - both high at expiry: SDA low, then SCL
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ms_params.svh"
module i2c_master_stop_arbitration (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire i2c_ms_pkg::line_t line_in,
  output var i2c_ms_pkg::line_t line_out,
  output var i2c_ms_pkg::line_t line_oe,
  input wire logic sleep_in,
  output logic port_irq,
  output logic wake
);
  i2c_ms_pkg::line_t sync1;
  i2c_ms_pkg::line_t line_s;
  i2c_ms_pkg::line_t line_p;
  i2c_ms_pkg::state_t state;
  i2c_ms_pkg::state_t next_state;
  i2c_ms_pkg::line_t next_oe;
  logic [6:0] ctrl;
  logic [6:0] reload;
  logic [6:0] baud_generator;
  logic [7:0] tbuf;
  logic [7:0] sh;
  logic [3:0] bitn;
  logic write_collision_flag, bf, bcol, pif, s_det, p_det;
  logic brg_load, load, pause, col, fin, tx_end, bit_done;
  logic tmo, en, busy, acc, wr, wr_buf, start_ev, stop_ev, hit;
  logic [31:0] rd;

  assign en = ctrl[`C_EN];
  assign busy = state != i2c_ms_pkg::IDLE;
  assign acc = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  assign wr_buf = wr && paddr == `OFF_BUF;
  assign tmo = (baud_generator == 7'h00) && !brg_load;
  assign start_ev = line_p.scl && line_s.scl && line_p.sda && !line_s.sda;
  assign stop_ev = line_p.scl && line_s.scl && !line_p.sda && line_s.sda;
  assign hit = paddr == `OFF_CTRL || paddr == `OFF_STAT ||
    paddr == `OFF_BUF || paddr == `OFF_BAUD;

  // two-stage line synchroniser, then one stage of history
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync1 <= 2'b11;
      line_s <= 2'b11;
      line_p <= 2'b11;
    end
    else
    begin
      sync1 <= line_in;
      line_s <= sync1;
      line_p <= line_s;
    end
  end

  // apb answer: one wait cycle, registered data
  always_comb
  begin
    rd = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL: rd[6:0] = ctrl;
      `OFF_STAT:
      begin
        rd[`S_WRITE_COLLISION_FLAG] = write_collision_flag;
        rd[`S_BF] = bf;
        rd[`S_BCOL] = bcol;
        rd[`S_PIF] = pif;
        rd[`S_START] = s_det;
        rd[`S_STOP] = p_det;
        rd[`S_BUSY] = busy;
      end
      `OFF_BUF: rd[7:0] = tbuf;
      `OFF_BAUD: rd[6:0] = reload;
      default: rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && !hit;
      prdata <= (acc && !pwrite) ? rd : 32'h0000_0000;
    end
  end

  // control bits; sequence enables only accepted while idle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ctrl <= `CTRL_RST;
    else
    begin
      if (wr && paddr == `OFF_CTRL)
      begin
        ctrl[`C_EN] <= pwdata[`C_EN];
        ctrl[`C_ACKDT] <= pwdata[`C_ACKDT];
        ctrl[`C_IRQEN] <= pwdata[`C_IRQEN];
        if (!busy)
          ctrl[`C_ACKEN:`C_SEN] <= pwdata[`C_ACKEN:`C_SEN];
      end
      if (fin || col || !en)
        ctrl[`C_ACKEN:`C_SEN] <= 4'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reload <= `BAUD_RST;
    else if (wr && paddr == `OFF_BAUD)
      reload <= pwdata[6:0];
  end

  // baud generator
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      baud_generator <= 7'h00;
    else if (brg_load)
      baud_generator <= reload;
    else if (pause)
      baud_generator <= baud_generator;
    else if (baud_generator != 7'h00)
      baud_generator <= baud_generator - 7'h01;
  end

  // transfer buffer and shifter
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tbuf <= 8'h00;
      sh <= 8'h00;
      bitn <= 4'h0;
    end
    else if (wr_buf && !busy)
    begin
      tbuf <= pwdata[7:0];
      sh <= pwdata[7:0];
      bitn <= 4'h0;
    end
    else if (bit_done)
    begin
      sh <= {sh[6:0], 1'b0};
      bitn <= bitn + 4'h1;
    end
  end

  // sequencer
  always_comb
  begin
    next_state = state;
    next_oe = line_oe;
    load = 1'b0;
    pause = 1'b0;
    col = 1'b0;
    fin = 1'b0;
    tx_end = 1'b0;
    bit_done = 1'b0;
    case (state)
      i2c_ms_pkg::IDLE:
        if (ctrl[`C_SEN])
          next_state = i2c_ms_pkg::ST_CHK;
        else if (ctrl[`C_RSEN])
        begin
          next_oe = 2'b10;
          load = 1'b1;
          next_state = i2c_ms_pkg::RS_LO;
        end
        else if (ctrl[`C_PEN])
        begin
          next_oe.sda = 1'b1;
          next_state = i2c_ms_pkg::SP_SDA;
        end
        else if (ctrl[`C_ACKEN])
        begin
          next_oe = {1'b1, !ctrl[`C_ACKDT]};
          load = 1'b1;
          next_state = i2c_ms_pkg::AK_LO;
        end
        else if (bf)
        begin
          next_oe = {1'b1, !sh[7]};
          load = 1'b1;
          next_state = i2c_ms_pkg::TX_LO;
        end
      i2c_ms_pkg::ST_CHK:
        if (!line_s.sda || !line_s.scl)
          col = 1'b1;
        else
        begin
          load = 1'b1;
          next_state = i2c_ms_pkg::ST_HI;
        end
      i2c_ms_pkg::ST_HI:
        if (!line_s.scl && line_s.sda)
          col = 1'b1;
        else if (!line_s.sda || tmo)
        begin
          next_oe.sda = 1'b1;
          load = 1'b1;
          next_state = i2c_ms_pkg::ST_LO;
        end
      i2c_ms_pkg::ST_LO:
        if (tmo)
        begin
          next_oe.scl = 1'b1;
          fin = 1'b1;
          next_state = i2c_ms_pkg::IDLE;
        end
      i2c_ms_pkg::RS_LO:
        if (tmo)
        begin
          next_oe.scl = 1'b0;
          next_state = i2c_ms_pkg::RS_REL;
        end
      i2c_ms_pkg::RS_REL:
      begin
        pause = 1'b1;
        if (line_s.scl && !line_s.sda)
          col = 1'b1;
        else if (line_s.scl)
        begin
          load = 1'b1;
          next_state = i2c_ms_pkg::RS_HI;
        end
      end
      i2c_ms_pkg::RS_HI:
        if (!line_s.scl && line_s.sda)
          col = 1'b1;
        else if (tmo)
        begin
          next_oe.sda = 1'b1;
          load = 1'b1;
          next_state = i2c_ms_pkg::RS_SDA;
        end
      i2c_ms_pkg::RS_SDA:
        if (tmo)
        begin
          next_oe.scl = 1'b1;
          fin = 1'b1;
          next_state = i2c_ms_pkg::IDLE;
        end
      i2c_ms_pkg::TX_LO, i2c_ms_pkg::AK_LO, i2c_ms_pkg::SP_LO:
        if (tmo)
        begin
          next_oe.scl = 1'b0;
          next_state = state == i2c_ms_pkg::TX_LO ? i2c_ms_pkg::TX_REL :
            state == i2c_ms_pkg::AK_LO ? i2c_ms_pkg::AK_REL :
            i2c_ms_pkg::SP_REL;
        end
      i2c_ms_pkg::TX_REL, i2c_ms_pkg::AK_REL, i2c_ms_pkg::SP_REL:
      begin
        // wait for SCL high, then reload
        pause = 1'b1;
        if (line_s.scl)
        begin
          load = 1'b1;
          next_state = state == i2c_ms_pkg::TX_REL ? i2c_ms_pkg::TX_HI :
            state == i2c_ms_pkg::AK_REL ? i2c_ms_pkg::AK_HI :
            i2c_ms_pkg::SP_HI;
        end
      end
      i2c_ms_pkg::TX_HI:
        if (!line_oe.sda && !line_s.sda && bitn != 4'h8)
          col = 1'b1;
        else if (tmo)
        begin
          next_oe.scl = 1'b1;
          bit_done = 1'b1;
          if (bitn == 4'h8)
          begin
            tx_end = 1'b1;
            next_state = i2c_ms_pkg::IDLE;
          end
          else
          begin
            // a one is sent by releasing the line, ninth slot released
            next_oe.sda = bitn != 4'h7 && !sh[6];
            load = 1'b1;
            next_state = i2c_ms_pkg::TX_LO;
          end
        end
      i2c_ms_pkg::AK_HI:
        if (!line_oe.sda && !line_s.sda)
          col = 1'b1;
        else if (tmo)
        begin
          next_oe.scl = 1'b1;
          fin = 1'b1;
          next_state = i2c_ms_pkg::IDLE;
        end
      i2c_ms_pkg::SP_SDA:
        if (!line_s.sda)
        begin
          load = 1'b1;
          next_state = i2c_ms_pkg::SP_LO;
        end
      i2c_ms_pkg::SP_HI:
        if (tmo)
        begin
          next_oe.sda = 1'b0;
          next_state = i2c_ms_pkg::SP_WAIT;
        end
      i2c_ms_pkg::SP_WAIT:
        if (line_s.sda && line_s.scl)
        begin
          load = 1'b1;
          next_state = i2c_ms_pkg::SP_END;
        end
      i2c_ms_pkg::SP_END:
        if (tmo)
        begin
          fin = 1'b1;
          next_state = i2c_ms_pkg::IDLE;
        end
      default: next_state = i2c_ms_pkg::IDLE;
    endcase
    // collision releases both lines, back to idle
    if (col || !en)
    begin
      next_state = i2c_ms_pkg::IDLE;
      next_oe = 2'b00;
      load = 1'b0;
      col = col && en;
      fin = 1'b0;
      tx_end = 1'b0;
      bit_done = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state <= i2c_ms_pkg::IDLE;
      line_oe <= 2'b00;
      line_out <= 2'b00;
      brg_load <= 1'b0;
    end
    else
    begin
      state <= next_state;
      line_oe <= next_oe;
      line_out <= 2'b00;
      brg_load <= load;
    end
  end

  // status flags: hardware set wins over write-one-to-clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      write_collision_flag <= 1'b0;
      bf <= 1'b0;
      bcol <= 1'b0;
      pif <= 1'b0;
    end
    else
    begin
      if (wr && paddr == `OFF_STAT)
      begin
        write_collision_flag <= write_collision_flag && !pwdata[`S_WRITE_COLLISION_FLAG];
        bcol <= bcol && !pwdata[`S_BCOL];
        pif <= pif && !pwdata[`S_PIF];
      end
      if (wr_buf && busy)
        write_collision_flag <= 1'b1;
      if (col)
        bcol <= 1'b1;
      // bus stop while idle and enabled raises port flag
      if (fin || tx_end || (stop_ev && en && !busy))
        pif <= 1'b1;
      if (col || tx_end || !en)
        bf <= 1'b0;
      else if (wr_buf && !busy)
        bf <= 1'b1;
    end
  end

  // bus monitor; software reads these before claiming bus
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !en)
    begin
      s_det <= 1'b0;
      p_det <= 1'b0;
    end
    else if (start_ev)
    begin
      s_det <= 1'b1;
      p_det <= 1'b0;
    end
    else if (stop_ev)
    begin
      s_det <= 1'b0;
      p_det <= 1'b1;
    end
  end

  // sequencer runs in sleep; wake on enabled flag
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      port_irq <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      port_irq <= pif && ctrl[`C_IRQEN];
      wake <= sleep_in && pif && ctrl[`C_IRQEN];
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_write_collision_flag;
    (wr_buf && busy) |=> write_collision_flag && $stable(tbuf);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("buffer write during sequence not refused");
  property p_stop_sda;
    (state == i2c_ms_pkg::IDLE && en && ctrl[`C_PEN] &&
      ctrl[`C_RSEN:`C_SEN] == 2'b00) |=> line_oe.sda;
  endproperty
  a_stop_sda: assert property (p_stop_sda)
    else $error("stop did not drive sda low");
  property p_stop_scl;
    (state == i2c_ms_pkg::SP_LO && tmo && en) |=>
      !line_oe.scl && line_oe.sda;
  endproperty
  a_stop_scl: assert property (p_stop_scl)
    else $error("stop scl release wrong");
  property p_stop_end;
    (state == i2c_ms_pkg::SP_END && tmo && en) |=> pif && !ctrl[`C_PEN];
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop end did not flag or clear");
  property p_pause;
    (pause && !line_s.scl && en && !brg_load) |=> $stable(baud_generator);
  endproperty
  a_pause: assert property (p_pause)
    else $error("baud counted while scl held low");
  property p_det_clr;
    !en |=> !s_det && !p_det;
  endproperty
  a_det_clr: assert property (p_det_clr)
    else $error("detect bits kept while disabled");
  property p_tx_col;
    (state == i2c_ms_pkg::TX_HI && en && !line_oe.sda && !line_s.sda &&
      bitn != 4'h8) |=> bcol && !bf && line_oe == 2'b00 && !busy;
  endproperty
  a_tx_col: assert property (p_tx_col)
    else $error("transmit collision not handled");
  property p_start_col;
    (state == i2c_ms_pkg::ST_CHK && en && !(line_s.sda && line_s.scl))
      |=> bcol && !busy && !ctrl[`C_SEN];
  endproperty
  a_start_col: assert property (p_start_col)
    else $error("start with low line not aborted");
  property p_rs_end;
    (state == i2c_ms_pkg::RS_SDA && tmo && en) |=>
      line_oe == 2'b11 && !busy ##1 !ctrl[`C_RSEN];
  endproperty
  a_rs_end: assert property (p_rs_end)
    else $error("repeated start end wrong");

  c_stop: cover property (state == i2c_ms_pkg::SP_END && tmo);
  c_col: cover property (col);
  c_start: cover property (state == i2c_ms_pkg::ST_LO && tmo);
  c_tx: cover property (tx_end);
endmodule : i2c_master_stop_arbitration
`default_nettype wire

// ### logic/i2c_ms_params.svh
/*
  Register offsets, field positions and reset values of the I2C master
  stop / arbitration block. Assumes a 32-bit APB slave with byte addresses.
*/
`ifndef I2C_MS_PARAMS_SVH
`define I2C_MS_PARAMS_SVH
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_BUF 8'h08
`define OFF_BAUD 8'h0c
`define C_EN 0
`define C_SEN 1
`define C_RSEN 2
`define C_PEN 3
`define C_ACKEN 4
`define C_ACKDT 5
`define C_IRQEN 6
`define S_WRITE_COLLISION_FLAG 0
`define S_BF 1
`define S_BCOL 2
`define S_PIF 3
`define S_START 4
`define S_STOP 5
`define S_BUSY 6
`define CTRL_RST 7'h00
`define BAUD_RST 7'h09
`endif

// ### logic/i2c_ms_pkg.sv
/*
  Types of the I2C master stop / arbitration block.
  Assumes i2c_ms_params.svh supplies offsets and field positions.
*/
package i2c_ms_pkg;
  typedef struct packed {
    logic scl;
    logic sda;
  } line_t;
  typedef enum logic [4:0] {
    IDLE = 5'b00000,
    ST_CHK = 5'b00001,
    ST_HI = 5'b00010,
    ST_LO = 5'b00011,
    RS_LO = 5'b00100,
    RS_REL = 5'b00101,
    RS_HI = 5'b00110,
    RS_SDA = 5'b00111,
    TX_LO = 5'b01000,
    TX_REL = 5'b01001,
    TX_HI = 5'b01010,
    AK_LO = 5'b01011,
    AK_REL = 5'b01100,
    AK_HI = 5'b01101,
    SP_SDA = 5'b01110,
    SP_LO = 5'b01111,
    SP_REL = 5'b10000,
    SP_HI = 5'b10001,
    SP_WAIT = 5'b10010,
    SP_END = 5'b10011
  } state_t;
endpackage : i2c_ms_pkg

// ### verif/bus_party.sv
/*
  Far-side party on the shared bus: open-drain pull-downs on SCL and SDA.
  Assumes the bench moves the pull commands just after mclk edges.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_party (
  input wire i2c_ms_pkg::line_t dut_oe,
  input wire i2c_ms_pkg::line_t pull,
  output var i2c_ms_pkg::line_t wire_lvl
);
  // wired-and lines with pull-ups
  always_comb
  begin
    wire_lvl.scl = !(dut_oe.scl || pull.scl);
    wire_lvl.sda = !(dut_oe.sda || pull.sda);
  end
endmodule : bus_party
`default_nettype wire

// ### verif/testbench.sv
/*
  Self-checking bench of the stop / arbitration block over APB.
  Assumes bus_party resolves the open-drain lines.
*/
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ms_params.svh"
module testbench;
  logic mclk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic perr;
  logic sleep_in;
  logic port_irq;
  logic wake;
  logic scl_q;
  logic [15:0] bits;
  i2c_ms_pkg::line_t line_in;
  i2c_ms_pkg::line_t line_oe;
  i2c_ms_pkg::line_t pull;
  int fail_count;
  int num_checks;
  int cyc;

  i2c_master_stop_arbitration dut_u (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in),
    .line_out(), .line_oe(line_oe), .sleep_in(sleep_in),
    .port_irq(port_irq), .wake(wake)
  );
  bus_party party_u (.dut_oe(line_oe), .pull(pull), .wire_lvl(line_in));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // collect SDA at each SCL rise
  always @(posedge mclk)
  begin
    scl_q <= line_in.scl;
    if (line_in.scl && !scl_q)
      bits <= {bits[14:0], line_in.sda};
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // pready ends this wait; only the bench timeout bounds it
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic poll(input logic [7:0] a, input int b, input logic v,
    output logic [31:0] q);
    int n;
    n = 0;
    rd(a, q);
    while (q[b] !== v && n < 300)
    begin
      rd(a, q);
      n++;
    end
  endtask : poll

  task automatic t_reset;
    logic [31:0] q;
    rd(`OFF_CTRL, q);
    check("ctrl", q, 32'h0);
    rd(`OFF_STAT, q);
    check("status", q, 32'h0);
    rd(`OFF_BAUD, q);
    check("baud", q, {25'h0, `BAUD_RST});
    rd(8'h10, q);
    check("unmapped err", {31'h0, perr}, 32'h1);
    check("lines", line_oe, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_start_coll;
    logic [31:0] q;
    pull <= 2'b01;
    // enable first: a disabled port drops sequence bits
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_CTRL, 32'h3);
    poll(`OFF_STAT, `S_BCOL, 1'b1, q);
    check("bcol", q[`S_BCOL], 32'h1);
    rd(`OFF_CTRL, q);
    check("seq bits", q[4:1], 32'h0);
    check("lines", line_oe, 32'h0);
    pull <= 2'b00;
    wr(`OFF_STAT, 32'hf);
    $display("test start collision done");
  endtask : t_start_coll

  task automatic do_tx(input logic [7:0] b);
    logic [31:0] q;
    // bus free: stop seen or both detect bits clear
    rd(`OFF_STAT, q);
    check("bus free", {31'h0, q[`S_STOP] || !q[`S_START]}, 32'h1);
    wr(`OFF_CTRL, 32'h3);
    poll(`OFF_CTRL, `C_SEN, 1'b0, q);
    check("start lines", line_oe, 32'h3);
    wr(`OFF_STAT, 32'h8);
    wr(`OFF_BUF, {24'h0, b});
    pull.scl <= 1'b1;
    repeat (20) @(posedge mclk);
    pull.scl <= 1'b0;
    poll(`OFF_STAT, `S_PIF, 1'b1, q);
    check("bf", q[`S_BF], 32'h0);
    check("bits", bits[8:0], {b, 1'b1});
    wr(`OFF_STAT, 32'h8);
  endtask : do_tx

  task automatic t_stop;
    logic [31:0] q;
    do_tx(8'ha5);
    wr(`OFF_CTRL, 32'h9);
    @(posedge mclk);
    check("stop first", line_oe, 32'h3);
    wr(`OFF_BUF, 32'h77);
    poll(`OFF_STAT, `S_PIF, 1'b1, q);
    check("write_collision_flag", q[`S_WRITE_COLLISION_FLAG], 32'h1);
    check("bf", q[`S_BF], 32'h0);
    check("stop det", q[`S_STOP], 32'h1);
    rd(`OFF_BUF, q);
    check("buffer kept", q, 32'ha5);
    rd(`OFF_CTRL, q);
    check("pen", q[`C_PEN], 32'h0);
    check("lines", line_oe, 32'h0);
    wr(`OFF_CTRL, 32'h0);
    rd(`OFF_STAT, q);
    check("detect off", q[5:4], 32'h0);
    wr(`OFF_STAT, 32'hf);
    $display("test stop done");
  endtask : t_stop

  task automatic t_coll;
    logic [31:0] q;
    int n;
    n = 0;
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_CTRL, 32'h3);
    poll(`OFF_CTRL, `C_SEN, 1'b0, q);
    wr(`OFF_BUF, 32'hff);
    while (!(line_in.scl && !scl_q) && n < 500)
    begin
      @(posedge mclk);
      n++;
    end
    pull.sda <= 1'b1;
    poll(`OFF_STAT, `S_BCOL, 1'b1, q);
    check("bcol", q[`S_BCOL], 32'h1);
    check("bf", q[`S_BF], 32'h0);
    check("lines", line_oe, 32'h0);
    rd(`OFF_CTRL, q);
    check("seq bits", q[4:1], 32'h0);
    wr(`OFF_CTRL, 32'h41);
    wr(`OFF_STAT, 32'h8);
    sleep_in <= 1'b1;
    // another master ends with a stop
    pull.scl <= 1'b1;
    repeat (8) @(posedge mclk);
    pull.scl <= 1'b0;
    repeat (8) @(posedge mclk);
    pull.sda <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(`OFF_STAT, q);
    check("pif", q[`S_PIF], 32'h1);
    check("irq", port_irq, 32'h1);
    check("wake", wake, 32'h1);
    sleep_in <= 1'b0;
    wr(`OFF_STAT, 32'hf);
    rd(`OFF_STAT, q);
    check("irq off", port_irq, 32'h0);
    do_tx(8'h3c);
    // repeated start from scl held low after the ninth bit
    wr(`OFF_CTRL, 32'h5);
    poll(`OFF_CTRL, `C_RSEN, 1'b0, q);
    check("rs lines", line_oe, 32'h3);
    rd(`OFF_STAT, q);
    check("rs pif", q[`S_PIF], 32'h1);
    wr(`OFF_STAT, 32'h8);
    $display("test collision done");
  endtask : t_coll

  task automatic t_rst;
    logic [31:0] q;
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_CTRL, 32'h3);
    poll(`OFF_CTRL, `C_SEN, 1'b0, q);
    wr(`OFF_BUF, 32'h11);
    repeat (15) @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("lines", line_oe, 32'h0);
    rd(`OFF_CTRL, q);
    check("ctrl", q, 32'h0);
    rd(`OFF_STAT, q);
    check("status", q, 32'h0);
    $display("test reset abort done");
  endtask : t_rst

  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    sleep_in = 1'b0;
    pull = 2'b00;
    bits = 16'h0;
    fail_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    wr(`OFF_BAUD, 32'h4);
    t_start_coll();
    t_stop();
    t_coll();
    t_rst();
    test_done();
  end
endmodule : testbench
`default_nettype wire
